// ==== hdl/dpgm_params.svh ====
`ifndef DPGM_PARAMS_SVH
`define DPGM_PARAMS_SVH

// Register indices on the plain register port
`define DPGM_ADDR_W 4
`define DPGM_IDX_H_DIR 4'h0
`define DPGM_IDX_H_PINS 4'h1
`define DPGM_IDX_H_LATCH 4'h2
`define DPGM_IDX_J_DIR 4'h3
`define DPGM_IDX_J_PINS 4'h4
`define DPGM_IDX_J_LATCH 4'h5
`define DPGM_IDX_ANALOG_CFG 4'h6
`define DPGM_IDX_EXT_BUS_CFG 4'h7

// Reset values
`define DPGM_DIR_RST 8'hff
`define DPGM_LATCH_POR 8'h00
`define DPGM_ANALOG_CFG_RST 8'h00
`define DPGM_EXT_BUS_CFG_RST 8'h00

// Writable field masks
`define DPGM_ANALOG_CFG_MASK 8'h3f
`define DPGM_EXT_BUS_CFG_MASK 8'hb3

// Field positions
`define DPGM_BUS_DISABLE_BIT 7
`define DPGM_PCFG_LSB 0
`define DPGM_PCFG_W 4
`define DPGM_PCFG_ALL_DIGITAL 4'hf

// Port J bit with no bus function
`define DPGM_J_FREE_BIT 5
`define DPGM_J_BUS_MASK 8'hdf

// Analog channel number of port H bit 4
`define DPGM_H_AN_BASE 5'h0c

`endif

// ==== hdl/dpgm_pkg.sv ====
package dpgm_pkg;

    typedef logic [7:0] dpgm_byte_t;

    typedef enum logic [1:0] {
        DPGM_FUNC_GPIO = 2'b00,
        DPGM_FUNC_BUS = 2'b01,
        DPGM_FUNC_PWM = 2'b10,
        DPGM_FUNC_ANALOG = 2'b11
    } dpgm_func_t;

endpackage

// ==== hdl/dpgm_pin_port.sv ====
`timescale 1ns/10ps
`default_nettype none

module dpgm_pin_port
    import dpgm_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Software state
    input wire logic [WIDTH-1:0] dir,
    input wire logic [WIDTH-1:0] latch,
    // Alternate function owning the pin
    input wire logic [WIDTH-1:0] alt_en,
    input wire logic [WIDTH-1:0] alt_out,
    input wire logic [WIDTH-1:0] alt_oe,
    // Peripheral direction override
    input wire logic [WIDTH-1:0] ovr_en,
    input wire logic [WIDTH-1:0] ovr_drive,
    // Pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pin_sync
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta_reg;
            logic out_next;
            logic oe_next;

            always_comb
            begin
                if (alt_en[i])
                begin
                    out_next = alt_out[i];
                    oe_next = alt_oe[i];
                end
                else if (ovr_en[i])
                begin
                    out_next = latch[i];
                    oe_next = ovr_drive[i];
                end
                else
                begin
                    out_next = latch[i];
                    oe_next = ~dir[i];
                end
            end

            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    pin_out[i] <= 1'b0;
                    pin_oe[i] <= 1'b0;
                end
                else
                begin
                    pin_out[i] <= out_next;
                    pin_oe[i] <= oe_next;
                end
            end

            // Two-stage synchroniser on the pin level
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    meta_reg <= 1'b0;
                    pin_sync[i] <= 1'b0;
                end
                else
                begin
                    meta_reg <= pin_in[i];
                    pin_sync[i] <= meta_reg;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ==== hdl/dpgm_top.sv ====
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dpgm_params.svh"

// Summary of operation
// - Port H has eight pins, each with its own direction bit.
// - Port H direction one tristates the pin, making it an input.
// - Port H direction zero drives the output latch bit onto the pin.
// - Reading port H latch register returns stored latch, not pin levels.
// - Port H pins 7..4 share analog channels 15..12, chosen by analog config.
// - After power-on, port H 7..4 are analog and read as zero.
// - Under bus ownership, port H 3..0 output address bits 19..16.
// - External bus config selects port H 3..0 as GPIO or bus pins.
// - After power-on, port H 3..0 carry bus address.
// - Port H low nibble uses Schmitt in GPIO, TTL in bus or PSP mode.
// - Port H 7..4 carry PWM outputs only while remap select is clear.
// - Port J has eight pins; direction one tristates, zero drives latch.
// - Reading port J latch register returns the stored latch value.
// - Port J bits other than 5 are GPIO only with bus disabled, else carry bus strobes.
// - Port J pin 5 stays GPIO regardless of bus enable.
// - An enabled peripheral may force a pin's direction, overriding direction bit.
// - Overrides never reach the direction register; reads show software value.
// - After power-on, port J pins other than 5 drive bus strobes; pin 5 is an input.
// - Port J bus bits: ALE, OE, low write, high write, byte address, none, byte selects.
module dpgm_top
    import dpgm_pkg::*;
(
    // Clock and resets
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    // Register port
    input wire logic [`DPGM_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Port H pins
    input wire logic [7:0] h_pin_in,
    output logic [7:0] h_pin_out,
    output logic [7:0] h_pin_oe,
    // Port J pins
    input wire logic [7:0] j_pin_in,
    output logic [7:0] j_pin_out,
    output logic [7:0] j_pin_oe,
    // External memory bus sources
    input wire logic [3:0] upper_address_bits,
    input wire logic [7:0] bus_strobes,
    // Enhanced PWM sources for port H 7..4
    input wire logic [3:0] pwm_out,
    input wire logic [3:0] pwm_en,
    input wire logic pwm_remap_select,
    // Peripheral direction overrides
    input wire logic [7:0] h_ovr_en,
    input wire logic [7:0] h_ovr_drive,
    input wire logic [7:0] j_ovr_en,
    input wire logic [7:0] j_ovr_drive,
    // Parallel slave port mode
    input wire logic psp_mode,
    // Pin configuration status
    output logic [3:0] h_analog_sel,
    output logic [3:0] h_ttl_sel
);

    logic any_rst;
    dpgm_byte_t h_dir_reg;
    dpgm_byte_t h_latch_reg;
    dpgm_byte_t j_dir_reg;
    dpgm_byte_t j_latch_reg;
    dpgm_byte_t analog_cfg_reg;
    dpgm_byte_t ext_bus_cfg_reg;
    dpgm_byte_t h_sync;
    dpgm_byte_t j_sync;
    dpgm_byte_t h_alt_en;
    dpgm_byte_t h_alt_out;
    dpgm_byte_t j_alt_en;
    dpgm_byte_t j_alt_out;
    dpgm_byte_t h_pins_read;
    dpgm_byte_t rdata_next;
    dpgm_func_t h_func [8];
    logic [`DPGM_PCFG_W-1:0] pcfg;
    logic [3:0] h_analog;
    logic bus_owned;
    logic wr_h_dir;
    logic wr_h_latch;
    logic wr_j_dir;
    logic wr_j_latch;

    assign any_rst = sys_rst | soft_rst;
    assign pcfg = analog_cfg_reg[`DPGM_PCFG_LSB +: `DPGM_PCFG_W];
    assign bus_owned = ~ext_bus_cfg_reg[`DPGM_BUS_DISABLE_BIT];

    // Write decode; pins and latch registers both load the latch
    assign wr_h_dir = reg_wr && (reg_addr == `DPGM_IDX_H_DIR);
    assign wr_h_latch = reg_wr && ((reg_addr == `DPGM_IDX_H_LATCH) || (reg_addr == `DPGM_IDX_H_PINS));
    assign wr_j_dir = reg_wr && (reg_addr == `DPGM_IDX_J_DIR);
    assign wr_j_latch = reg_wr && ((reg_addr == `DPGM_IDX_J_LATCH) || (reg_addr == `DPGM_IDX_J_PINS));

    // Direction registers, set to inputs on any reset
    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            h_dir_reg <= `DPGM_DIR_RST;
            j_dir_reg <= `DPGM_DIR_RST;
        end
        else
        begin
            if (wr_h_dir)
                h_dir_reg <= reg_wdata;
            if (wr_j_dir)
                j_dir_reg <= reg_wdata;
        end
    end

    // Output latches survive every reset but power-on
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            h_latch_reg <= `DPGM_LATCH_POR;
            j_latch_reg <= `DPGM_LATCH_POR;
        end
        // Writes ignored while a soft reset holds
        else if (!soft_rst)
        begin
            if (wr_h_latch)
                h_latch_reg <= reg_wdata;
            if (wr_j_latch)
                j_latch_reg <= reg_wdata;
        end
    end

    // Pin configuration registers
    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            analog_cfg_reg <= `DPGM_ANALOG_CFG_RST;
            ext_bus_cfg_reg <= `DPGM_EXT_BUS_CFG_RST;
        end
        else
        begin
            if (reg_wr && (reg_addr == `DPGM_IDX_ANALOG_CFG))
                analog_cfg_reg <= reg_wdata & `DPGM_ANALOG_CFG_MASK;
            if (reg_wr && (reg_addr == `DPGM_IDX_EXT_BUS_CFG))
                ext_bus_cfg_reg <= reg_wdata & `DPGM_EXT_BUS_CFG_MASK;
        end
    end

    // Function owning each port H pin
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_h_func
            if (i < 4)
            begin : g_lo
                assign h_func[i] = bus_owned ? DPGM_FUNC_BUS : DPGM_FUNC_GPIO;
                assign h_alt_en[i] = bus_owned;
                assign h_alt_out[i] = upper_address_bits[i];
            end
            else
            begin : g_hi
                logic [4:0] chan;
                logic pwm_on;
                assign chan = `DPGM_H_AN_BASE + 5'(i - 4);
                // Channel n analog while pcfg + n stays within 15
                assign h_analog[i-4] = (pcfg != `DPGM_PCFG_ALL_DIGITAL)
                    && ({1'b0, pcfg} + chan <= 5'h0f);
                assign pwm_on = pwm_en[i-4] & ~pwm_remap_select;
                assign h_func[i] = pwm_on ? DPGM_FUNC_PWM
                    : (h_analog[i-4] ? DPGM_FUNC_ANALOG : DPGM_FUNC_GPIO);
                assign h_alt_en[i] = (h_func[i] == DPGM_FUNC_PWM) || (h_func[i] == DPGM_FUNC_ANALOG);
                assign h_alt_out[i] = (h_func[i] == DPGM_FUNC_PWM) & pwm_out[i-4];
            end
        end
    endgenerate

    // Port J: all bits but pin 5 go to the bus strobes
    generate
        for (i = 0; i < 8; i++)
        begin : g_j_func
            if (i == `DPGM_J_FREE_BIT)
            begin : g_free
                assign j_alt_en[i] = 1'b0;
            end
            else
            begin : g_bus
                assign j_alt_en[i] = bus_owned;
            end
            assign j_alt_out[i] = bus_strobes[i];
        end
    endgenerate

    // Alternate functions on port H drive except analog
    dpgm_byte_t h_alt_oe;
    always_comb
    begin
        h_alt_oe = 8'h00;
        for (int k = 0; k < 8; k++)
            h_alt_oe[k] = (h_func[k] == DPGM_FUNC_BUS) || (h_func[k] == DPGM_FUNC_PWM);
    end

    dpgm_pin_port #(
        .WIDTH(8)
    ) u_port_h (
        .sys_clk(sys_clk),
        .rst(any_rst),
        .dir(h_dir_reg),
        .latch(h_latch_reg),
        .alt_en(h_alt_en),
        .alt_out(h_alt_out),
        .alt_oe(h_alt_oe),
        .ovr_en(h_ovr_en & ~h_alt_en),
        .ovr_drive(h_ovr_drive),
        .pin_in(h_pin_in),
        .pin_out(h_pin_out),
        .pin_oe(h_pin_oe),
        .pin_sync(h_sync)
    );

    dpgm_pin_port #(
        .WIDTH(8)
    ) u_port_j (
        .sys_clk(sys_clk),
        .rst(any_rst),
        .dir(j_dir_reg),
        .latch(j_latch_reg),
        .alt_en(j_alt_en),
        .alt_out(j_alt_out),
        .alt_oe(j_alt_en),
        .ovr_en(j_ovr_en & ~j_alt_en),
        .ovr_drive(j_ovr_drive),
        .pin_in(j_pin_in),
        .pin_out(j_pin_out),
        .pin_oe(j_pin_oe),
        .pin_sync(j_sync)
    );

    // Analog pins read as zero
    assign h_pins_read = h_sync & ~{h_analog, 4'h0};

    always_comb
    begin
        case (reg_addr)
            `DPGM_IDX_H_DIR: rdata_next = h_dir_reg;
            `DPGM_IDX_H_PINS: rdata_next = h_pins_read;
            `DPGM_IDX_H_LATCH: rdata_next = h_latch_reg;
            `DPGM_IDX_J_DIR: rdata_next = j_dir_reg;
            `DPGM_IDX_J_PINS: rdata_next = j_sync;
            `DPGM_IDX_J_LATCH: rdata_next = j_latch_reg;
            `DPGM_IDX_ANALOG_CFG: rdata_next = analog_cfg_reg;
            `DPGM_IDX_EXT_BUS_CFG: rdata_next = ext_bus_cfg_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_next;
        else
            reg_rdata <= 8'h00;
    end

    // Configuration status outputs
    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            h_analog_sel <= 4'hf;
            h_ttl_sel <= 4'hf;
        end
        else
        begin
            h_analog_sel <= h_analog;
            h_ttl_sel <= {4{bus_owned | psp_mode}};
        end
    end

    a_h_input_hiz: assert property (@(posedge sys_clk) disable iff (any_rst)
        ((h_dir_reg & ~h_alt_en & ~h_ovr_en) != 8'h00)
        |=> ((h_pin_oe & $past(h_dir_reg & ~h_alt_en & ~h_ovr_en)) == 8'h00))
        else $error("Port H input pin still driven");

    a_h_drive_latch: assert property (@(posedge sys_clk) disable iff (any_rst)
        1'b1 |=> (((h_pin_out ^ $past(h_latch_reg)) & $past(~h_dir_reg & ~h_alt_en & ~h_ovr_en)) == 8'h00)
        && ((~h_pin_oe & $past(~h_dir_reg & ~h_alt_en & ~h_ovr_en)) == 8'h00))
        else $error("Port H output pin not driving latch");

    a_h_latch_read: assert property (@(posedge sys_clk) disable iff (any_rst)
        (reg_rd && (reg_addr == `DPGM_IDX_H_LATCH)) |=> (reg_rdata == $past(h_latch_reg)))
        else $error("Port H latch read wrong");

    a_h_analog_zero: assert property (@(posedge sys_clk) disable iff (any_rst)
        (reg_rd && (reg_addr == `DPGM_IDX_H_PINS) && (pcfg == 4'h0)) |=> (reg_rdata[7:4] == 4'h0))
        else $error("Analog pin read not zero");

    a_h_addr_drive: assert property (@(posedge sys_clk) disable iff (any_rst)
        bus_owned |=> (h_pin_out[3:0] == $past(upper_address_bits)) && (h_pin_oe[3:0] == 4'hf))
        else $error("Upper address not on port H");

    a_j_bus_strobes: assert property (@(posedge sys_clk) disable iff (any_rst)
        bus_owned |=> ((j_pin_out & `DPGM_J_BUS_MASK) == ($past(bus_strobes) & `DPGM_J_BUS_MASK))
        && ((j_pin_oe & `DPGM_J_BUS_MASK) == `DPGM_J_BUS_MASK))
        else $error("Bus strobes not on port J");

    a_j_pin5_free: assert property (@(posedge sys_clk) disable iff (any_rst)
        (bus_owned && !j_ovr_en[5]) |=> (j_pin_oe[5] == !$past(j_dir_reg[5])))
        else $error("Port J pin 5 taken by bus");

    a_pwm_route: assert property (@(posedge sys_clk) disable iff (any_rst)
        (pwm_remap_select && (h_analog == 4'h0) && (h_ovr_en[7:4] == 4'h0))
        |=> (h_pin_oe[7:4] == ~$past(h_dir_reg[7:4])))
        else $error("PWM output not released on remap");

    a_ovr_not_stored: assert property (@(posedge sys_clk) disable iff (any_rst)
        (!wr_h_dir && (h_ovr_en != 8'h00)) |=> (h_dir_reg == $past(h_dir_reg)))
        else $error("Override leaked into direction");

    a_dir_reset: assert property (@(posedge sys_clk)
        soft_rst |=> (h_dir_reg == `DPGM_DIR_RST) && (j_dir_reg == `DPGM_DIR_RST)
        && (h_latch_reg == $past(h_latch_reg)))
        else $error("Soft reset handling wrong");

    a_ttl_select: assert property (@(posedge sys_clk) disable iff (any_rst)
        1'b1 |=> (h_ttl_sel == ($past(bus_owned || psp_mode) ? 4'hf : 4'h0)))
        else $error("Threshold select wrong");

    a_j_gpio_free: assert property (@(posedge sys_clk) disable iff (any_rst)
        (!bus_owned && (j_ovr_en == 8'h00)) |=> (j_pin_oe == ~$past(j_dir_reg)))
        else $error("Port J not under direction control");

    a_analog_undriven: assert property (@(posedge sys_clk) disable iff (any_rst)
        1'b1 |=> ((h_pin_oe[7:4] & $past(h_analog & ~(pwm_en & ~{4{pwm_remap_select}}))) == 4'h0))
        else $error("Analog pin driven");

endmodule

`default_nettype wire

// ==== tb/dpgm_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// Outside world of one port: a pin shows the device drive, else the external level
module dpgm_pin_model
(
    // Device side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // External drivers
    input wire logic [7:0] ext_level,
    // Level seen back
    output logic [7:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dpgm_params.svh"

module tb_top
    import dpgm_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic soft_rst = 1'b0;
    logic [`DPGM_ADDR_W-1:0] reg_addr = 4'h0;
    dpgm_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic psp_mode = 1'b0;
    logic pwm_remap_select = 1'b0;
    logic [3:0] upper_address_bits = 4'ha;
    logic [3:0] pwm_out = 4'h9;
    logic [3:0] pwm_en = 4'h0;
    logic [7:0] bus_strobes = 8'h5a;
    logic [7:0] ext_h = 8'hc3;
    logic [7:0] ext_j = 8'h81;
    logic [7:0] h_ovr_en = 8'h00;
    logic [7:0] h_ovr_drive = 8'h00;
    logic [7:0] j_ovr_en = 8'h00;
    logic [7:0] j_ovr_drive = 8'h00;
    logic [7:0] reg_rdata, h_pin_in, h_pin_out, h_pin_oe, j_pin_in, j_pin_out, j_pin_oe;
    logic [3:0] h_analog_sel, h_ttl_sel;
    dpgm_byte_t rd_val;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;

    always #50 sys_clk = ~sys_clk;

    dpgm_top i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .h_pin_in(h_pin_in), .h_pin_out(h_pin_out), .h_pin_oe(h_pin_oe),
        .j_pin_in(j_pin_in), .j_pin_out(j_pin_out), .j_pin_oe(j_pin_oe),
        .upper_address_bits(upper_address_bits), .bus_strobes(bus_strobes),
        .pwm_out(pwm_out), .pwm_en(pwm_en), .pwm_remap_select(pwm_remap_select),
        .h_ovr_en(h_ovr_en), .h_ovr_drive(h_ovr_drive), .j_ovr_en(j_ovr_en),
        .j_ovr_drive(j_ovr_drive), .psp_mode(psp_mode),
        .h_analog_sel(h_analog_sel), .h_ttl_sel(h_ttl_sel)
    );

    dpgm_pin_model i_h_world (.pin_out(h_pin_out), .pin_oe(h_pin_oe), .ext_level(ext_h), .pin_in(h_pin_in));
    dpgm_pin_model i_j_world (.pin_out(j_pin_out), .pin_oe(j_pin_oe), .ext_level(ext_j), .pin_in(j_pin_in));

    task automatic tally_and_finish;
        if (err_total == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            tally_and_finish;
        end
    end

    task automatic chk(input dpgm_byte_t got, input dpgm_byte_t exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobe dropped at the closing edge, so back-to-back calls never collide
    task automatic wr(input logic [`DPGM_ADDR_W-1:0] a, input dpgm_byte_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [`DPGM_ADDR_W-1:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask

    task automatic rdchk(input logic [`DPGM_ADDR_W-1:0] a, input dpgm_byte_t e);
        rd(a);
        chk(rd_val, e);
    endtask

    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_reset;
        settle;
        chk(h_pin_oe, 8'h0f);
        chk(h_pin_out & 8'h0f, 8'h0a);
        chk({4'h0, h_analog_sel}, 8'h0f);
        chk({4'h0, h_ttl_sel}, 8'h0f);
        chk(j_pin_oe, 8'hdf);
        chk(j_pin_out & 8'hdf, 8'h5a);
        rdchk(`DPGM_IDX_H_DIR, 8'hff);
        rdchk(`DPGM_IDX_J_DIR, 8'hff);
        rdchk(`DPGM_IDX_ANALOG_CFG, 8'h00);
        rdchk(`DPGM_IDX_EXT_BUS_CFG, 8'h00);
        rd(`DPGM_IDX_H_PINS);
        chk(rd_val & 8'hf0, 8'h00);
        @(posedge sys_clk);
        #1;
        chk(reg_rdata, 8'h00);
        @(posedge sys_clk);
        upper_address_bits <= 4'h5;
        settle;
        chk(h_pin_out & 8'h0f, 8'h05);
    endtask

    task automatic t_h_gpio;
        wr(`DPGM_IDX_EXT_BUS_CFG, 8'h80);
        wr(`DPGM_IDX_ANALOG_CFG, 8'h0f);
        wr(`DPGM_IDX_H_LATCH, 8'ha5);
        wr(`DPGM_IDX_H_DIR, 8'h0f);
        settle;
        chk(h_pin_oe, 8'hf0);
        chk(h_pin_out & 8'hf0, 8'ha0);
        chk({4'h0, h_ttl_sel}, 8'h00);
        rdchk(`DPGM_IDX_H_LATCH, 8'ha5);
        rdchk(`DPGM_IDX_H_PINS, 8'ha3);
        wr(`DPGM_IDX_H_PINS, 8'h3c);
        wr(`DPGM_IDX_H_DIR, 8'h69);
        settle;
        chk(h_pin_oe, 8'h96);
        chk(h_pin_out & 8'h96, 8'h14);
        rdchk(`DPGM_IDX_H_LATCH, 8'h3c);
        @(posedge sys_clk);
        psp_mode <= 1'b1;
        settle;
        chk({4'h0, h_ttl_sel}, 8'h0f);
        @(posedge sys_clk);
        psp_mode <= 1'b0;
    endtask

    // Every pin configuration code against the analog channel map
    task automatic t_analog;
        logic [3:0] e;
        wr(`DPGM_IDX_H_DIR, 8'hff);
        for (int p = 0; p < 16; p++)
        begin
            wr(`DPGM_IDX_ANALOG_CFG, 8'(p));
            settle;
            for (int i = 0; i < 4; i++)
                e[i] = (p != 15) && (p + 12 + i <= 15);
            chk({4'h0, h_analog_sel}, {4'h0, e});
        end
        rd(`DPGM_IDX_H_PINS);
        chk(rd_val & 8'hf0, 8'hc0);
        wr(`DPGM_IDX_ANALOG_CFG, 8'hff);
        rdchk(`DPGM_IDX_ANALOG_CFG, 8'h3f);
        wr(`DPGM_IDX_EXT_BUS_CFG, 8'hff);
        rdchk(`DPGM_IDX_EXT_BUS_CFG, 8'hb3);
        wr(4'h8, 8'hff);
        rdchk(4'h8, 8'h00);
    endtask

    task automatic t_port_j;
        wr(`DPGM_IDX_EXT_BUS_CFG, 8'h80);
        wr(`DPGM_IDX_J_LATCH, 8'h3c);
        wr(`DPGM_IDX_J_DIR, 8'h00);
        settle;
        chk(j_pin_oe, 8'hff);
        chk(j_pin_out, 8'h3c);
        wr(`DPGM_IDX_J_DIR, 8'hf0);
        settle;
        chk(j_pin_oe, 8'h0f);
        rdchk(`DPGM_IDX_J_LATCH, 8'h3c);
        rdchk(`DPGM_IDX_J_PINS, 8'h8c);
        wr(`DPGM_IDX_J_DIR, 8'h00);
        wr(`DPGM_IDX_EXT_BUS_CFG, 8'h00);
        settle;
        chk(j_pin_oe, 8'hff);
        chk(j_pin_out, 8'h7a);
        wr(`DPGM_IDX_EXT_BUS_CFG, 8'h80);
    endtask

    task automatic t_override;
        wr(`DPGM_IDX_H_DIR, 8'hff);
        wr(`DPGM_IDX_J_DIR, 8'h00);
        wr(`DPGM_IDX_H_LATCH, 8'h01);
        @(posedge sys_clk);
        h_ovr_en <= 8'h01;
        h_ovr_drive <= 8'h01;
        j_ovr_en <= 8'h80;
        settle;
        chk(h_pin_oe, 8'h01);
        chk(h_pin_out & 8'h01, 8'h01);
        chk(j_pin_oe, 8'h7f);
        rdchk(`DPGM_IDX_H_DIR, 8'hff);
        rdchk(`DPGM_IDX_J_DIR, 8'h00);
        @(posedge sys_clk);
        h_ovr_en <= 8'h00;
        j_ovr_en <= 8'h00;
    endtask

    task automatic t_pwm;
        wr(`DPGM_IDX_H_DIR, 8'hff);
        @(posedge sys_clk);
        pwm_en <= 4'hf;
        settle;
        chk(h_pin_oe & 8'hf0, 8'hf0);
        chk(h_pin_out & 8'hf0, 8'h90);
        @(posedge sys_clk);
        pwm_remap_select <= 1'b1;
        settle;
        chk(h_pin_oe & 8'hf0, 8'h00);
    endtask

    task automatic t_resets;
        wr(`DPGM_IDX_H_LATCH, 8'h5a);
        wr(`DPGM_IDX_J_LATCH, 8'h33);
        wr(`DPGM_IDX_H_DIR, 8'h00);
        wr(`DPGM_IDX_ANALOG_CFG, 8'h2f);
        @(posedge sys_clk);
        soft_rst <= 1'b1;
        @(posedge sys_clk);
        soft_rst <= 1'b0;
        rdchk(`DPGM_IDX_H_DIR, 8'hff);
        rdchk(`DPGM_IDX_H_LATCH, 8'h5a);
        rdchk(`DPGM_IDX_J_LATCH, 8'h33);
        rdchk(`DPGM_IDX_ANALOG_CFG, 8'h00);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rdchk(`DPGM_IDX_H_LATCH, 8'h00);
        rdchk(`DPGM_IDX_J_DIR, 8'hff);
        settle;
        chk({4'h0, h_analog_sel}, 8'h0f);
    endtask

    initial
    begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset;
        t_h_gpio;
        t_analog;
        t_port_j;
        t_override;
        t_pwm;
        t_resets;
        tally_and_finish;
    end
endmodule

`default_nettype wire
